/* File: tgc_config_regs.v */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "tgc_defs.vh"

// Summary of operation
// - Activation bit 0 clear blocks access to the unit's runtime registers.
// - Base address high/low bytes read/write, low byte bits 1:0 read 00.
// - Interrupt select routes the expiry output and holds wake enable.
// - Interrupt kind resets to 03h; only bit 1 is writable.
// - Both DMA report registers read constant 04h, writes ignored.
// - Unit configuration register resets to 02h, power mode set.
// - Configuration bit 3 picks expiry buffer: 0 open-drain, 1 push-pull.
// - Configuration bit 2 set enables the expiry pin pull-up.
// - Power bit clear stops timer clock, holds expiry deasserted (driven high in push-pull, released in open-drain), keeps registers.
// - Power bit set lets the timer run whenever the unit is active.
// - Tristate bit set with unit inactive floats the unit's output pins.
module tgc_config_regs #(
  parameter ADDR_WIDTH = 12
) (
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  // AXI4-Lite write address
  input wire awvalid,
  output reg awready,
  input wire [ADDR_WIDTH-1:0] awaddr,
  input wire [2:0] awprot,
  // AXI4-Lite write data
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output reg arready,
  input wire [ADDR_WIDTH-1:0] araddr,
  input wire [2:0] arprot,
  // AXI4-Lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Timer side, same clock
  input wire timer_expiry_n,
  output reg timer_clock_enable,
  output reg runtime_regs_enable,
  output reg [15:0] base_address,
  // Interrupt routing of the expiry output
  output reg [3:0] expiry_irq_number,
  output reg expiry_wake_enable,
  output reg expiry_irq_level,
  output reg expiry_irq_high,
  // Expiry output pin
  output reg expiry_output_n_o,
  output reg expiry_output_oe,
  output reg expiry_pullup_enable
);

  // Register storage
  reg [7:0] unit_activate;
  reg [7:0] base_address_high;
  reg [7:0] base_address_low;
  reg [7:0] interrupt_select;
  reg [7:0] interrupt_kind;
  reg [7:0] unit_configuration;

  // Write channel bookkeeping
  reg aw_full;
  reg w_full;
  reg [ADDR_WIDTH-1:0] aw_addr_q;
  reg [7:0] w_byte_q;
  reg w_lane0_q;

  wire aw_take;
  wire w_take;
  wire ar_take;
  wire have_aw;
  wire have_w;
  wire do_write;
  wire [ADDR_WIDTH-1:0] wr_addr;
  wire [7:0] wr_byte;
  wire wr_lane0;
  wire [9:0] wr_index;
  wire [9:0] rd_index;

  reg next_aw_full;
  reg next_w_full;
  reg next_bvalid;
  reg next_rvalid;

  // Status of the unit
  wire unit_active;
  wire power_normal;
  wire outputs_floated;
  wire expiry_asserted;

  function is_mapped;
    input [9:0] index;
    begin
      case (index)
        `TGC_IDX_ACTIVATE,
        `TGC_IDX_BASE_HIGH,
        `TGC_IDX_BASE_LOW,
        `TGC_IDX_INT_SELECT,
        `TGC_IDX_INT_KIND,
        `TGC_IDX_DMA_FIRST,
        `TGC_IDX_DMA_SECOND,
        `TGC_IDX_UNIT_CFG: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Only the bits in mask take the new value; the rest keep the old one
  function [7:0] merge_byte;
    input [7:0] old_value;
    input [7:0] new_value;
    input [7:0] mask;
    begin
      merge_byte = (old_value & ~mask) | (new_value & mask);
    end
  endfunction

  function [9:0] index_of;
    input [ADDR_WIDTH-1:0] addr;
    begin
      index_of = addr[11:2];
    end
  endfunction

  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign have_aw = aw_full | aw_take;
  assign have_w = w_full | w_take;
  // Address and data may arrive in either order; write once both are held
  assign do_write = have_aw & have_w & ~bvalid;
  assign wr_addr = aw_full ? aw_addr_q : awaddr;
  assign wr_byte = w_full ? w_byte_q : wdata[7:0];
  assign wr_lane0 = w_full ? w_lane0_q : wstrb[0];
  assign wr_index = index_of(wr_addr);
  assign rd_index = index_of(araddr);

  always @* begin
    next_aw_full = have_aw & ~do_write;
    next_w_full = have_w & ~do_write;
    next_bvalid = do_write | (bvalid & ~bready);
    next_rvalid = ar_take | (rvalid & ~rready);
  end

  // Write handshake and response
  // Limitation: with aclken low the ready outputs hold their level, so the
  // bus master must share the same enable or a handshake it sees is lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= {ADDR_WIDTH{1'b0}};
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TGC_RESP_OKAY;
    end else if (aclken) begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_byte_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      awready <= ~next_aw_full & ~next_bvalid;
      wready <= ~next_w_full & ~next_bvalid;
      bvalid <= next_bvalid;
      if (do_write) begin
        bresp <= is_mapped(wr_index) ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
      end
    end
  end

  // Register writes; only byte lane 0 carries data
  always @(posedge aclk) begin
    if (!aresetn) begin
      unit_activate <= `TGC_RST_ACTIVATE;
      base_address_high <= `TGC_RST_BASE_HIGH;
      base_address_low <= `TGC_RST_BASE_LOW;
      interrupt_select <= `TGC_RST_INT_SELECT;
      interrupt_kind <= `TGC_RST_INT_KIND;
      unit_configuration <= `TGC_RST_UNIT_CFG;
    end else if (aclken && do_write && wr_lane0) begin
      case (wr_index)
        `TGC_IDX_ACTIVATE: begin
          unit_activate <= merge_byte(unit_activate, wr_byte,
                                      `TGC_WMASK_ACTIVATE);
        end
        `TGC_IDX_BASE_HIGH: begin
          base_address_high <= merge_byte(base_address_high, wr_byte,
                                          `TGC_WMASK_BASE_HIGH);
        end
        `TGC_IDX_BASE_LOW: begin
          base_address_low <= merge_byte(base_address_low, wr_byte,
                                         `TGC_WMASK_BASE_LOW);
        end
        `TGC_IDX_INT_SELECT: begin
          interrupt_select <= merge_byte(interrupt_select, wr_byte,
                                         `TGC_WMASK_INT_SELECT);
        end
        `TGC_IDX_INT_KIND: begin
          interrupt_kind <= merge_byte(interrupt_kind, wr_byte,
                                       `TGC_WMASK_INT_KIND);
        end
        `TGC_IDX_UNIT_CFG: begin
          unit_configuration <= merge_byte(unit_configuration, wr_byte,
                                           `TGC_WMASK_UNIT_CFG);
        end
        // DMA reports and unmapped indexes ignore writes
        default: begin
          unit_activate <= unit_activate;
        end
      endcase
    end
  end

  // Read path; registers stay readable whatever the power mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `TGC_RESP_OKAY;
    end else if (aclken) begin
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (ar_take) begin
        rresp <= is_mapped(rd_index) ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
        case (rd_index)
          `TGC_IDX_ACTIVATE: rdata <= {24'h000000, unit_activate};
          `TGC_IDX_BASE_HIGH: rdata <= {24'h000000, base_address_high};
          `TGC_IDX_BASE_LOW: rdata <= {24'h000000, base_address_low};
          `TGC_IDX_INT_SELECT: rdata <= {24'h000000, interrupt_select};
          `TGC_IDX_INT_KIND: rdata <= {24'h000000, interrupt_kind};
          `TGC_IDX_DMA_FIRST,
          `TGC_IDX_DMA_SECOND: begin
            rdata <= {24'h000000, `TGC_VAL_DMA_REPORT};
          end
          `TGC_IDX_UNIT_CFG: begin
            rdata <= {24'h000000, unit_configuration};
          end
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign unit_active = unit_activate[`TGC_ACT_BIT];
  assign power_normal = unit_configuration[`TGC_CFG_POWER];
  assign outputs_floated = unit_configuration[`TGC_CFG_TRISTATE] &
                           ~unit_active;
  // Low power mode masks the timer, so the pin sits at its idle high level
  assign expiry_asserted = ~timer_expiry_n & unit_active & power_normal;

  // Unit outputs, registered so the pins never glitch on decode
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_clock_enable <= 1'b0;
      runtime_regs_enable <= 1'b0;
      base_address <= 16'h0000;
      expiry_irq_number <= 4'h0;
      expiry_wake_enable <= 1'b0;
      expiry_irq_level <= 1'b0;
      expiry_irq_high <= 1'b1;
      expiry_output_n_o <= 1'b1;
      expiry_output_oe <= 1'b0;
      expiry_pullup_enable <= 1'b0;
    end else if (aclken) begin
      runtime_regs_enable <= unit_active;
      timer_clock_enable <= unit_active & power_normal;
      base_address <= {base_address_high, base_address_low};
      expiry_irq_number <=
        interrupt_select[`TGC_INTSEL_NUM_MSB:0];
      expiry_wake_enable <= interrupt_select[`TGC_INTSEL_WAKE];
      expiry_irq_level <= expiry_asserted;
      expiry_irq_high <= interrupt_kind[1];
      expiry_pullup_enable <= unit_configuration[`TGC_CFG_PULLUP];
      if (outputs_floated) begin
        expiry_output_n_o <= 1'b1;
        expiry_output_oe <= 1'b0;
      end else if (unit_configuration[`TGC_CFG_PUSHPULL]) begin
        expiry_output_n_o <= ~expiry_asserted;
        expiry_output_oe <= 1'b1;
      end else begin
        // Open-drain only ever pulls low; high comes from the pull-up
        expiry_output_n_o <= 1'b0;
        expiry_output_oe <= expiry_asserted;
      end
    end
  end

endmodule // tgc_config_regs

/* File: tgc_config_regs_monitor.sv */
`timescale 1ns/1ps
module tgc_monitor (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  // Register bus
  input wire awready,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  // Timer and pin
  input wire timer_expiry_n,
  input wire timer_clock_enable,
  input wire runtime_regs_enable,
  input wire [15:0] base_address,
  input wire expiry_irq_level,
  input wire expiry_output_n_o,
  input wire expiry_output_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer moved");
  property p_r_answer;
    aclken && arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_busy;
    bvalid |-> !awready && !wready;
  endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_upper;
    rvalid |-> rdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_base;
    base_address[1:0] == 2'h0;
  endproperty
  a_base: assert property (p_base)
    else $error("base low bits set");
  property p_clk_act;
    timer_clock_enable |-> runtime_regs_enable;
  endproperty
  a_clk_act: assert property (p_clk_act)
    else $error("timer runs idle");
  property p_low_pwr;
    !timer_clock_enable |-> !(expiry_output_oe && !expiry_output_n_o);
  endproperty
  a_low_pwr: assert property (p_low_pwr)
    else $error("pin low, timer off");
  // A frozen edge holds the level, so only judge edges after an enabled one
  property p_irq;
    $past(aclken) |->
      expiry_irq_level == (!$past(timer_expiry_n) && timer_clock_enable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq level wrong");
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_irq: cover property (expiry_irq_level);
endmodule // tgc_monitor

bind tgc_config_regs tgc_monitor u_tgc_monitor (.*);

/* File: tgc_defs.vh */
`ifndef TGC_DEFS_VH
`define TGC_DEFS_VH

// Register indexes; the byte address of each register is four times these
`define TGC_IDX_ACTIVATE 10'h030
`define TGC_IDX_BASE_HIGH 10'h060
`define TGC_IDX_BASE_LOW 10'h061
`define TGC_IDX_INT_SELECT 10'h070
`define TGC_IDX_INT_KIND 10'h071
`define TGC_IDX_DMA_FIRST 10'h074
`define TGC_IDX_DMA_SECOND 10'h075
`define TGC_IDX_UNIT_CFG 10'h0F0

// Reset values
`define TGC_RST_ACTIVATE 8'h00
`define TGC_RST_BASE_HIGH 8'h00
`define TGC_RST_BASE_LOW 8'h00
`define TGC_RST_INT_SELECT 8'h00
`define TGC_RST_INT_KIND 8'h03
`define TGC_VAL_DMA_REPORT 8'h04
`define TGC_RST_UNIT_CFG 8'h02

// Writable bit masks
`define TGC_WMASK_ACTIVATE 8'hFF
`define TGC_WMASK_BASE_HIGH 8'hFF
`define TGC_WMASK_BASE_LOW 8'hFC
`define TGC_WMASK_INT_SELECT 8'hFF
`define TGC_WMASK_INT_KIND 8'h02
`define TGC_WMASK_UNIT_CFG 8'h0F

// Field positions
`define TGC_ACT_BIT 0
`define TGC_CFG_TRISTATE 0
`define TGC_CFG_POWER 1
`define TGC_CFG_PULLUP 2
`define TGC_CFG_PUSHPULL 3
`define TGC_INTSEL_WAKE 4
`define TGC_INTSEL_NUM_MSB 3

// AXI response codes
`define TGC_RESP_OKAY 2'h0
`define TGC_RESP_SLVERR 2'h2

`endif

/* File: tgc_tb.sv */
`timescale 1ns/1ps
module testbench;
  localparam [95:0] AD = {12'h3C0, 12'h1D4, 12'h1D0, 12'h1C4,
    12'h1C0, 12'h184, 12'h180, 12'h0C0};
  localparam [63:0] RV = 64'h0204040300000000;
  localparam [63:0] WM = 64'h0F000002FFFCFFFF;
  reg aclk = 0;
  reg aresetn = 0;
  // Protection is not decoded; strobe and clock enable are stepped below
  reg aclken = 1;
  reg [2:0] awprot = 3'h0;
  reg [2:0] arprot = 3'h0;
  reg [3:0] wstrb = 4'hF;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg timer_expiry_n = 1;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire timer_clock_enable, runtime_regs_enable, expiry_wake_enable;
  wire [15:0] base_address;
  wire [3:0] expiry_irq_number;
  wire expiry_irq_level, expiry_irq_high, expiry_output_n_o;
  wire expiry_output_oe, expiry_pullup_enable;
  wire [2:0] pin_st;
  assign pin_st = {expiry_output_n_o, expiry_output_oe, expiry_irq_level};
  integer bad_count = 0, n_tests = 0, cyc = 0;

  tgc_config_regs u_tgc_config_regs (.*);

  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end

  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task wr(input [11:0] a, input [7:0] v, input [1:0] er);
    reg aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= a;
    wdata <= {24'h0, v};
    bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task rd(input [11:0] a, input [7:0] ev, input [1:0] er);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    chk("rdata", {24'h0, ev}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task t_regs;
    reg [7:0] v;
    integer i, p;
    for (i = 0; i < 8; i = i + 1)
      rd(AD[i*12 +: 12], RV[i*8 +: 8], 2'h0);
    for (p = 0; p < 2; p = p + 1) begin
      v = p ? 8'h5A : 8'hA5;
      for (i = 0; i < 8; i = i + 1)
        wr(AD[i*12 +: 12], v, 2'h0);
      for (i = 0; i < 8; i = i + 1)
        rd(AD[i*12 +: 12], (RV[i*8 +: 8] & ~WM[i*8 +: 8]) |
          (v & WM[i*8 +: 8]), 2'h0);
      chk("outs", {v, v & 8'hFC, v[3:0], v[4], v[1], v[2], v[0], v[0] & v[1]},
        {base_address, expiry_irq_number, expiry_wake_enable, expiry_irq_high,
        expiry_pullup_enable, runtime_regs_enable,
        timer_clock_enable});
    end
  endtask

  task t_unmapped;
    wr(12'h3C4, 8'hFF, 2'h2);
    rd(12'h3C4, 8'h00, 2'h2);
  endtask

  task pin(input [7:0] act, input [7:0] cfg, input ex_n, input [2:0] e);
    wr(12'h0C0, act, 2'h0);
    wr(12'h3C0, cfg, 2'h0);
    @(posedge aclk);
    timer_expiry_n <= ex_n;
    repeat (3) @(posedge aclk);
    chk("pin", {29'h0, e},
      {29'h0, expiry_output_n_o, expiry_output_oe, expiry_irq_level});
  endtask

  task t_pin;
    pin(8'h01, 8'h02, 1'b0, 3'b011);
    pin(8'h01, 8'h0A, 1'b1, 3'b110);
    pin(8'h01, 8'h0A, 1'b0, 3'b011);
    pin(8'h01, 8'h08, 1'b0, 3'b110);
    rd(12'h3C0, 8'h08, 2'h0);
    pin(8'h00, 8'h03, 1'b0, 3'b100);
    pin(8'h00, 8'h02, 1'b0, 3'b000);
  endtask

  // Clock enable low freezes the outputs; lane 0 strobe off leaves data
  task t_freeze;
    wr(12'h0C0, 8'h01, 2'h0);
    repeat (3) @(posedge aclk);
    chk("frz_pin", 32'h3, {29'h0, pin_st});
    aclken <= 0;
    timer_expiry_n <= 1;
    repeat (4) @(posedge aclk);
    chk("frz_hold", 32'h3, {29'h0, pin_st});
    aclken <= 1;
    repeat (3) @(posedge aclk);
    chk("frz_run", 32'h0, {29'h0, pin_st});
    wstrb <= 4'hE;
    wr(12'h0C0, 8'h00, 2'h0);
    wstrb <= 4'hF;
    rd(12'h0C0, 8'h01, 2'h0);
  endtask

  task end_sim;
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_unmapped;
    t_pin;
    t_freeze;
    end_sim;
  end
endmodule // testbench
